/* File: rtl/nvc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the program-memory controller
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH
`define NVC_OFS_CTL 2'h0
`define NVC_OFS_ADDRL 2'h1
`define NVC_OFS_ADDRH 2'h2
`define NVC_OFS_WDATA 2'h3
`define NVC_HOFS_STATUS 3'h4
`define NVC_HOFS_FLAGS 3'h5
`define NVC_BIT_ERASE 0
`define NVC_BIT_WRITE 1
`define NVC_BIT_STOP 2
`define NVC_BIT_SWBUSY 6
`define NVC_BIT_BUSY 7
`define NVC_BIT_FULL 0
`define NVC_BIT_VIOL 1
`define NVC_PAGES 64
`define NVC_PAGE_BYTES 2048
`define NVC_WORD_ADDR_W 15
`define NVC_BYTE_ADDR_W 17
`define NVC_ERASED_WORD 32'hFFFFFFFF
`define NVC_CLK_MHZ 250
`define NVC_PAGE_ERASE_MS 20
`define NVC_CHIP_ERASE_MS 200
`define NVC_WORD_PROG_US 20
`define NVC_PAGE_ERASE_CYC (`NVC_PAGE_ERASE_MS * 1000 * `NVC_CLK_MHZ)
`define NVC_CHIP_ERASE_CYC (`NVC_CHIP_ERASE_MS * 1000 * `NVC_CLK_MHZ)
`define NVC_WORD_PROG_CYC (`NVC_WORD_PROG_US * `NVC_CLK_MHZ)
`endif

/* File: rtl/nvc_device.sv */
// Program-memory controller: word programming, page and chip erase, fetch guard
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "nvc_cfg.svh"
module nvc_device #(
	parameter int unsigned PAGE_ERASE_CYC = `NVC_PAGE_ERASE_CYC,
	parameter int unsigned CHIP_ERASE_CYC = `NVC_CHIP_ERASE_CYC,
	parameter int unsigned WORD_PROG_CYC = `NVC_WORD_PROG_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Link to CPU and DMA side
	nvc_if.dev bus,
	// Debug chip erase and clock mode
	input wire logic chipEraseReq,
	input wire logic lowFreqClk,
	// Array macro
	output logic [`NVC_WORD_ADDR_W-1:0] arrWordAddr_r,
	output logic [31:0] arrData_r,
	output logic arrProg_r,
	output logic arrErasePage_r,
	output logic arrEraseAll_r,
	output logic [5:0] arrPage_r,
	output logic arrRdEn_r,
	output logic [`NVC_BYTE_ADDR_W-1:0] arrRdAddr_r,
	output logic arrPowerDown_r,
	input wire logic [7:0] arrRdata
);
	if (PAGE_ERASE_CYC < 1 || CHIP_ERASE_CYC < 1 || WORD_PROG_CYC < 1)
		$error("nvc_device: operation counts must be at least one cycle");
	if (`NVC_PAGES * `NVC_PAGE_BYTES != (1 << `NVC_BYTE_ADDR_W))
		$error("nvc_device: array geometry mismatch");

	function automatic logic [31:0] setLane(input logic [31:0] w, input logic [1:0] lane,
		input logic [7:0] b);
		logic [31:0] r;
		r = w;
		r[{lane, 3'h0} +: 8] = b;
		return r;
	endfunction

	nvc_pkg::nvc_state_t state_r, state_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [6:0] addrH_r;
	logic [7:0] addrL_r;
	logic [`NVC_WORD_ADDR_W-1:0] wordAddr_r, wordAddr_nxt;
	logic [31:0] word_r, word_nxt;
	logic [1:0] byteCnt_r, byteCnt_nxt;
	logic pendProg_r, pendProg_nxt;
	logic trig_r, trig_nxt;
	logic prog_nxt, erasePage_nxt, eraseAll_nxt;
	logic [7:0] rdata_r;
	logic [7:0] fetchData_r;
	logic fetchValid_r, fetchDenied_r, rdPend_r;

	wire wrCtl = bus.regWr && bus.regAddr == `NVC_OFS_CTL;
	wire wrAddrL = bus.regWr && bus.regAddr == `NVC_OFS_ADDRL;
	wire wrAddrH = bus.regWr && bus.regAddr == `NVC_OFS_ADDRH;
	wire wrData = bus.regWr && bus.regAddr == `NVC_OFS_WDATA;
	wire isIdle = state_r == nvc_pkg::ST_IDLE;
	wire isWaitB = state_r == nvc_pkg::ST_WAITB;
	wire swBusy = state_r == nvc_pkg::ST_PROG;
	wire busy = !isIdle;
	wire cntDone = cnt_r == 32'h0;
	wire reqErase = wrCtl && bus.regWdata[`NVC_BIT_ERASE];
	wire reqWrite = wrCtl && bus.regWdata[`NVC_BIT_WRITE];
	wire reqStop = wrCtl && !bus.regWdata[`NVC_BIT_WRITE];
	wire [`NVC_WORD_ADDR_W-1:0] startAddr = {addrH_r, addrL_r};
	wire [7:0] ctlView = {busy, swBusy, 4'h0,
		isWaitB || swBusy || pendProg_r,
		state_r == nvc_pkg::ST_ERASE || state_r == nvc_pkg::ST_CHIP};
	wire [7:0] rdMux = bus.regAddr == `NVC_OFS_CTL ? ctlView :
		bus.regAddr == `NVC_OFS_ADDRL ? addrL_r :
		bus.regAddr == `NVC_OFS_ADDRH ? {1'b0, addrH_r} : 8'h00;
	wire fetchOk = bus.fetchRd && !busy;
	wire fetchBad = bus.fetchRd && busy;

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cntDone ? cnt_r : cnt_r - 32'h1;
		wordAddr_nxt = wordAddr_r;
		word_nxt = word_r;
		byteCnt_nxt = byteCnt_r;
		pendProg_nxt = pendProg_r;
		trig_nxt = 1'b0;
		prog_nxt = 1'b0;
		erasePage_nxt = 1'b0;
		eraseAll_nxt = 1'b0;
		unique case (state_r)
			nvc_pkg::ST_IDLE:
			begin
				if (chipEraseReq)
				begin
					state_nxt = nvc_pkg::ST_CHIP;
					cnt_nxt = CHIP_ERASE_CYC - 1;
					eraseAll_nxt = 1'b1;
				end
				else if (reqErase)
				begin
					state_nxt = nvc_pkg::ST_ERASE;
					cnt_nxt = PAGE_ERASE_CYC - 1;
					erasePage_nxt = 1'b1;
					pendProg_nxt = reqWrite;
				end
				else if (reqWrite)
				begin
					state_nxt = nvc_pkg::ST_WAITB;
					wordAddr_nxt = startAddr;
					byteCnt_nxt = 2'h0;
					trig_nxt = 1'b1;
				end
			end
			nvc_pkg::ST_ERASE, nvc_pkg::ST_CHIP:
			begin
				if (cntDone)
				begin
					pendProg_nxt = 1'b0;
					if (pendProg_r)
					begin
						state_nxt = nvc_pkg::ST_WAITB;
						wordAddr_nxt = startAddr;
						byteCnt_nxt = 2'h0;
						trig_nxt = 1'b1;
					end
					else
						state_nxt = nvc_pkg::ST_IDLE;
				end
			end
			nvc_pkg::ST_WAITB:
			begin
				if (wrData)
				begin
					word_nxt = setLane(word_r, byteCnt_r, bus.regWdata);
					byteCnt_nxt = byteCnt_r + 2'h1;
					if (byteCnt_r == 2'h3)
					begin
						state_nxt = nvc_pkg::ST_PROG;
						cnt_nxt = WORD_PROG_CYC - 1;
						prog_nxt = 1'b1;
					end
					else
						trig_nxt = 1'b1;
				end
				else if (reqStop)
					state_nxt = nvc_pkg::ST_IDLE;
			end
			nvc_pkg::ST_PROG:
			begin
				if (cntDone)
				begin
					state_nxt = nvc_pkg::ST_WAITB;
					wordAddr_nxt = wordAddr_r + 15'h1;
					trig_nxt = 1'b1;
				end
			end
			default:
				state_nxt = nvc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			state_r <= nvc_pkg::ST_IDLE;
			cnt_r <= 32'h0;
			addrH_r <= 7'h00;
			addrL_r <= 8'h00;
			wordAddr_r <= 15'h0000;
			word_r <= 32'h0;
			byteCnt_r <= 2'h0;
			pendProg_r <= 1'b0;
			trig_r <= 1'b0;
			rdata_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			wordAddr_r <= wordAddr_nxt;
			word_r <= word_nxt;
			byteCnt_r <= byteCnt_nxt;
			pendProg_r <= pendProg_nxt;
			trig_r <= trig_nxt;
			rdata_r <= bus.regRd ? rdMux : 8'h00;
			if (wrAddrL && isIdle)
				addrL_r <= bus.regWdata;
			if (wrAddrH && isIdle)
				addrH_r <= bus.regWdata[6:0];
		end
	end

	// Array command outputs
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			arrWordAddr_r <= 15'h0000;
			arrData_r <= `NVC_ERASED_WORD;
			arrProg_r <= 1'b0;
			arrErasePage_r <= 1'b0;
			arrEraseAll_r <= 1'b0;
			arrPage_r <= 6'h00;
		end
		else
		begin
			arrProg_r <= prog_nxt;
			arrErasePage_r <= erasePage_nxt;
			arrEraseAll_r <= eraseAll_nxt;
			if (prog_nxt)
			begin
				arrWordAddr_r <= wordAddr_r;
				arrData_r <= word_nxt;
			end
			else if (erasePage_nxt || eraseAll_nxt)
				arrData_r <= `NVC_ERASED_WORD;
			if (erasePage_nxt)
				arrPage_r <= addrH_r[6:1];
		end
	end

	// CPU byte reads of the array
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			arrRdEn_r <= 1'b0;
			arrRdAddr_r <= 17'h00000;
			arrPowerDown_r <= 1'b0;
			rdPend_r <= 1'b0;
			fetchData_r <= 8'h00;
			fetchValid_r <= 1'b0;
			fetchDenied_r <= 1'b0;
		end
		else
		begin
			arrRdEn_r <= fetchOk;
			if (fetchOk)
				arrRdAddr_r <= bus.fetchAddr;
			rdPend_r <= fetchOk;
			fetchValid_r <= rdPend_r;
			if (rdPend_r)
				fetchData_r <= arrRdata;
			fetchDenied_r <= fetchBad;
			arrPowerDown_r <= lowFreqClk && !fetchOk && !rdPend_r;
		end
	end

	assign bus.regRdata = rdata_r;
	assign bus.dmaTrig = trig_r;
	assign bus.fetchData = fetchData_r;
	assign bus.fetchValid = fetchValid_r;
	assign bus.fetchDenied = fetchDenied_r;
endmodule // nvc_device

/* File: rtl/nvc_host.sv */
// CPU and DMA side: forwards software orders, feeds data bytes on trigger, polls status
`timescale 1ns/1ps
`include "nvc_cfg.svh"
module nvc_host (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Link to controller
	nvc_if.host bus,
	// Software port
	input wire logic [2:0] swAddr,
	input wire logic [7:0] swWdata,
	input wire logic swWr,
	input wire logic swRd,
	output logic [7:0] swRdata_r,
	// CPU fetch port
	input wire logic cpuFetch,
	input wire logic [`NVC_BYTE_ADDR_W-1:0] cpuFetchAddr,
	output logic [7:0] cpuData_r,
	output logic cpuValid_r,
	output logic cpuDenied_r
);
	logic [1:0] regAddr_r;
	logic [7:0] regWdata_r, status_r, byteHold_r;
	logic regWr_r, regRd_r, pollPend_r, byteFull_r, trigPend_r, viol_r;
	logic fetchRd_r;
	logic [`NVC_BYTE_ADDR_W-1:0] fetchAddr_r;

	wire swFwd = swWr && swAddr < 3'h3;
	wire swData = swWr && swAddr == 3'h3;
	wire swClrViol = swWr && swAddr == `NVC_HOFS_FLAGS && swWdata[`NVC_BIT_VIOL];
	wire feed = !swFwd && byteFull_r && trigPend_r;
	wire [7:0] flags = {6'h00, viol_r, byteFull_r};
	wire [7:0] swMux = swAddr == `NVC_HOFS_STATUS ? status_r :
		swAddr == `NVC_HOFS_FLAGS ? flags : 8'h00;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			regAddr_r <= 2'h0;
			regWdata_r <= 8'h00;
			regWr_r <= 1'b0;
			regRd_r <= 1'b0;
			pollPend_r <= 1'b0;
			status_r <= 8'h00;
			byteHold_r <= 8'h00;
			byteFull_r <= 1'b0;
			trigPend_r <= 1'b0;
			viol_r <= 1'b0;
			swRdata_r <= 8'h00;
		end
		else
		begin
			regWr_r <= swFwd || feed;
			regRd_r <= !swFwd && !feed;
			regAddr_r <= swFwd ? swAddr[1:0] : feed ? `NVC_OFS_WDATA : `NVC_OFS_CTL;
			regWdata_r <= swFwd ? swWdata : byteHold_r;
			pollPend_r <= regRd_r;
			if (pollPend_r)
				status_r <= bus.regRdata;
			if (swData)
				byteHold_r <= swWdata;
			byteFull_r <= swData || (byteFull_r && !feed);
			trigPend_r <= bus.dmaTrig || (trigPend_r && !feed);
			viol_r <= bus.fetchDenied || (viol_r && !swClrViol);
			swRdata_r <= swRd ? swMux : 8'h00;
		end
	end

	// Fetch path
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			fetchRd_r <= 1'b0;
			fetchAddr_r <= 17'h00000;
			cpuData_r <= 8'h00;
			cpuValid_r <= 1'b0;
			cpuDenied_r <= 1'b0;
		end
		else
		begin
			fetchRd_r <= cpuFetch;
			fetchAddr_r <= cpuFetchAddr;
			cpuValid_r <= bus.fetchValid;
			if (bus.fetchValid)
				cpuData_r <= bus.fetchData;
			cpuDenied_r <= bus.fetchDenied;
		end
	end

	assign bus.regAddr = regAddr_r;
	assign bus.regWdata = regWdata_r;
	assign bus.regWr = regWr_r;
	assign bus.regRd = regRd_r;
	assign bus.fetchRd = fetchRd_r;
	assign bus.fetchAddr = fetchAddr_r;
endmodule // nvc_host

/* File: rtl/nvc_if.sv */
// Register, trigger and fetch link between the controller and its CPU/DMA side
`timescale 1ns/1ps
interface nvc_if;
	logic [1:0] regAddr;
	logic [7:0] regWdata;
	logic regWr;
	logic regRd;
	logic [7:0] regRdata;
	logic dmaTrig;
	logic fetchRd;
	logic [16:0] fetchAddr;
	logic [7:0] fetchData;
	logic fetchValid;
	logic fetchDenied;
	modport dev (
		input regAddr, regWdata, regWr, regRd, fetchRd, fetchAddr,
		output regRdata, dmaTrig, fetchData, fetchValid, fetchDenied
	);
	modport host (
		output regAddr, regWdata, regWr, regRd, fetchRd, fetchAddr,
		input regRdata, dmaTrig, fetchData, fetchValid, fetchDenied
	);
endinterface

/* File: rtl/nvc_pkg.sv */
// Types used by the device end of the program-memory controller
package nvc_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ERASE = 5'h02,
		ST_CHIP = 5'h04,
		ST_WAITB = 5'h08,
		ST_PROG = 5'h10
	} nvc_state_t;
endpackage

/* File: verification/nvc_assertions.sv */
// Concurrent checks on the link between controller and host side
`timescale 1ns/1ps
module nvc_assertions (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Link signals
	input wire logic [1:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic dmaTrig,
	input wire logic fetchRd,
	input wire logic fetchValid,
	input wire logic fetchDenied
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	strobe_excl_a: assert property (!(regWr && regRd))
		else $error("read and write strobes together");
	fetch_answer_a: assert property (fetchRd |=> fetchDenied or ##1 fetchValid)
		else $error("fetch not answered");
	fetch_excl_a: assert property (!(fetchValid && fetchDenied))
		else $error("fetch both valid and denied");
	denied_cause_a: assert property (fetchDenied |-> $past(fetchRd))
		else $error("denial without fetch");
	valid_delay_a: assert property (fetchValid |-> $past(fetchRd, 2))
		else $error("fetch data at wrong cycle");
	trig_pulse_a: assert property (dmaTrig |=> !dmaTrig)
		else $error("trigger longer than one cycle");
	rdata_idle_a: assert property (!regRd |=> regRdata == 8'h00)
		else $error("read data outside answer cycle");
	busy_flag_a: assert property (regRd && regAddr == 2'h0 |=>
		!(regRdata[6] || regRdata[0]) || regRdata[7]) else $error("busy flag missing");
	cover property (dmaTrig);
	cover property (fetchDenied);
	cover property (regRd ##1 regRdata[0]);
	cover property (regRd ##1 regRdata[6]);
endmodule // nvc_assertions

/* File: verification/tb_nvm_program_erase_ctrl.sv */
// Self-checking bench for both ends of the program-memory controller
`timescale 1ns/1ps
module tb_nvm_program_erase_ctrl;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic chipEraseReq = 1'b0;
	logic lowFreqClk = 1'b0;
	logic [2:0] swAddr = 3'h0;
	logic [7:0] swWdata = 8'h00;
	logic swWr = 1'b0;
	logic swRd = 1'b0;
	logic cpuFetch = 1'b0;
	logic [16:0] cpuFetchAddr = 17'h00000;
	logic [7:0] swRdata, cpuData, arrRdata;
	logic cpuValid, cpuDenied, arrProg, arrErasePage, arrEraseAll, arrRdEn, arrPd;
	logic [14:0] arrWordAddr, wa;
	logic [31:0] arrData, acc;
	logic [5:0] arrPage, page;
	logic [16:0] arrRdAddr;
	logic [31:0] seed = 32'h00005275;
	logic [31:0] expW[$];
	logic [14:0] expA[$];
	logic eraseSeen = 1'b0;
	logic chipSeen = 1'b0;
	time eraseT;
	time trigT = 0;
	int cnt;
	int num_errors = 0;
	int samples_checked = 0;
	always #2 mclk = ~mclk;
	assign arrRdata = arrRdAddr[7:0] ^ 8'h5A;
	nvc_if bus ();
	nvc_device #(.PAGE_ERASE_CYC(20), .CHIP_ERASE_CYC(40), .WORD_PROG_CYC(8)) u_nvc_device (
		.mclk(mclk), .rstn(rstn), .bus(bus), .chipEraseReq(chipEraseReq),
		.lowFreqClk(lowFreqClk), .arrWordAddr_r(arrWordAddr), .arrData_r(arrData),
		.arrProg_r(arrProg), .arrErasePage_r(arrErasePage), .arrEraseAll_r(arrEraseAll),
		.arrPage_r(arrPage), .arrRdEn_r(arrRdEn), .arrRdAddr_r(arrRdAddr),
		.arrPowerDown_r(arrPd), .arrRdata(arrRdata));
	nvc_host u_nvc_host (.mclk(mclk), .rstn(rstn), .bus(bus), .swAddr(swAddr),
		.swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata_r(swRdata),
		.cpuFetch(cpuFetch), .cpuFetchAddr(cpuFetchAddr), .cpuData_r(cpuData),
		.cpuValid_r(cpuValid), .cpuDenied_r(cpuDenied));
	nvc_assertions u_nvc_assertions (.mclk(mclk), .rstn(rstn), .regAddr(bus.regAddr),
		.regWr(bus.regWr), .regRd(bus.regRd), .regRdata(bus.regRdata),
		.dmaTrig(bus.dmaTrig), .fetchRd(bus.fetchRd), .fetchValid(bus.fetchValid),
		.fetchDenied(bus.fetchDenied));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic swW(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		swAddr <= a;
		swWdata <= d;
		swWr <= 1'b1;
		@(posedge mclk);
		swWr <= 1'b0;
	endtask
	task automatic swR(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		swAddr <= a;
		swRd <= 1'b1;
		@(posedge mclk);
		swRd <= 1'b0;
		@(negedge mclk);
		d = swRdata;
	endtask
	task automatic waitIdle();
		logic [7:0] s;
		int n;
		n = 0;
		repeat (4) @(posedge mclk);
		do
		begin
			swR(3'h4, s);
			n++;
		end
		while (s[7] !== 1'b0 && n < 200);
		chk("idle reached", {31'h0, n < 200}, 1);
	endtask
	task automatic start(input logic [7:0] c);
		logic [7:0] h;
		logic [7:0] l;
		h = rnd();
		l = rnd();
		swW(3'h2, h);
		swW(3'h1, l);
		swW(3'h0, c);
		wa = {h[6:0], l};
		page = h[6:1];
		cnt = 0;
	endtask
	task automatic feed(input int n);
		logic [7:0] b;
		logic [7:0] f;
		int g;
		repeat (n)
		begin
			b = rnd();
			swW(3'h3, b);
			acc = {b, acc[31:8]};
			cnt++;
			if (cnt == 4)
			begin
				expW.push_back(acc);
				expA.push_back(wa);
				wa++;
				cnt = 0;
			end
			g = 0;
			do
			begin
				swR(3'h5, f);
				g++;
			end
			while (f[0] !== 1'b0 && g < 50);
			chk("byte taken", {31'h0, f[0]}, 0);
		end
	endtask
	task automatic fetch(input logic [16:0] a, input logic den);
		int g;
		@(posedge mclk);
		cpuFetch <= 1'b1;
		cpuFetchAddr <= a;
		@(posedge mclk);
		cpuFetch <= 1'b0;
		g = 0;
		while (cpuValid !== 1'b1 && cpuDenied !== 1'b1 && g < 8)
		begin
			@(negedge mclk);
			g++;
		end
		chk("fetch answer", {31'h0, cpuValid | cpuDenied}, 1);
		chk("fetch denied", {31'h0, cpuDenied}, {31'h0, den});
		if (!den)
			chk("fetch data", {24'h0, cpuData}, {24'h0, a[7:0] ^ 8'h5A});
	endtask
	always @(negedge mclk)
	begin
		if (bus.dmaTrig && trigT < eraseT)
			trigT = $time;
		if (arrRdEn)
			chk("read power", {31'h0, arrPd}, 0);
		if (arrProg)
		begin
			chk("prog addr", {17'h0, arrWordAddr}, {17'h0, expA.pop_front()});
			chk("prog word", arrData, expW.pop_front());
			chk("erase first", {31'h0, eraseSeen}, 1);
		end
		if (arrErasePage)
		begin
			eraseSeen = 1'b1;
			eraseT = $time;
			chk("erase page", {26'h0, arrPage}, {26'h0, page});
			chk("erase data", arrData, 32'hFFFFFFFF);
		end
		if (arrEraseAll)
		begin
			chipSeen = 1'b1;
			chk("chip data", arrData, 32'hFFFFFFFF);
		end
	end
	initial
	begin
		logic [7:0] s;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		swR(3'h4, s);
		chk("status reset", {24'h0, s}, 0);
		fetch(17'h00123, 1'b0);
		start(8'h03);
		fetch(17'h00040, 1'b1);
		swR(3'h5, s);
		chk("violation", {31'h0, s[1]}, 1);
		swW(3'h5, 8'h02);
		swR(3'h5, s);
		chk("violation clr", {31'h0, s[1]}, 0);
		feed(8);
		chk("erase time", 32'(trigT - eraseT), 32'd80);
		repeat (12) @(posedge mclk);
		swW(3'h0, 8'h00);
		waitIdle();
		chk("words left", expA.size(), 0);
		start(8'h02);
		feed(2);
		repeat (4) @(posedge mclk);
		swW(3'h0, 8'h00);
		waitIdle();
		start(8'h02);
		feed(4);
		repeat (12) @(posedge mclk);
		swW(3'h0, 8'h00);
		waitIdle();
		chk("restart words", expA.size(), 0);
		chipEraseReq <= 1'b1;
		@(posedge mclk);
		chipEraseReq <= 1'b0;
		waitIdle();
		chk("chip erase", {31'h0, chipSeen}, 1);
		lowFreqClk <= 1'b1;
		repeat (3) @(negedge mclk);
		chk("power down", {31'h0, arrPd}, 1);
		fetch({9'h1FF, rnd()}, 1'b0);
		wrap_up();
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		wrap_up();
	end
endmodule // tb_nvm_program_erase_ctrl
